// file: ric_controller.sv
`default_nettype none
`include "ric_params.svh"

module ric_controller
	import ric_pkg::*;
#(
	parameter int FIFO_DEPTH = 512
) (
	input  wire logic                   clk_in,      // 50 MHz system clock
	input  wire logic                   rst_in,      // sync reset, high
	input  wire logic [`RIC_ADDR_W-1:0] addr_in,     // register address
	input  wire logic [`RIC_DATA_W-1:0] wr_data_in,  // write data
	input  wire logic                   wr_in,       // write strobe
	input  wire logic                   rd_in,       // read strobe
	input  wire ric_events_type         events_in,   // unit events
	output logic      [`RIC_DATA_W-1:0] rd_data_out, // read data, next cycle
	output logic                        irq_out,     // pending, active high
	output logic                        irq_pin_out  // interrupt pin level
);

	ric_state_type cur;
	ric_state_type next_cur;

	// bit 7 of the write decides set or clear of the ones below it
	function automatic logic [`RIC_FLAG_W-1:0] qualify_write(
		input logic [`RIC_FLAG_W-1:0] old_val,
		input logic [`RIC_DATA_W-1:0] wdata
	);
		logic [`RIC_FLAG_W-1:0] bits;
		bits = wdata[`RIC_FLAG_W-1:0];
		if (wdata[`RIC_QUAL_BIT]) begin
			qualify_write = old_val | bits;
		end else begin
			qualify_write = old_val & ~bits;
		end
	endfunction

	// the bits that a write clears, for set-wins merging
	function automatic logic [`RIC_FLAG_W-1:0] clear_bits(
		input logic [`RIC_DATA_W-1:0] wdata
	);
		if (wdata[`RIC_QUAL_BIT]) begin
			clear_bits = '0;
		end else begin
			clear_bits = wdata[`RIC_FLAG_W-1:0];
		end
	endfunction

	// the bits that a write forces on
	function automatic logic [`RIC_FLAG_W-1:0] set_bits(
		input logic [`RIC_DATA_W-1:0] wdata
	);
		if (wdata[`RIC_QUAL_BIT]) begin
			set_bits = wdata[`RIC_FLAG_W-1:0];
		end else begin
			set_bits = '0;
		end
	endfunction

	// address decode for the write strobes; the read mux decodes with its own case
	function automatic logic hit(
		input logic [`RIC_ADDR_W-1:0] a,
		input logic [`RIC_ADDR_W-1:0] ofs
	);
		hit = (a == ofs);
	endfunction

	// FIFO alert levels from the single water level
	logic [`RIC_CNT_W:0] water_wide;
	logic [`RIC_CNT_W:0] count_wide;
	logic [`RIC_CNT_W:0] depth_wide;
	logic                fifo_high_status;
	logic                fifo_low_status;

	// high alert counts down from the top, low alert up from the bottom
	always_comb begin
		water_wide = {{(`RIC_CNT_W + 1 - `RIC_DATA_W){1'b0}}, cur.water};
		count_wide = {1'b0, events_in.fifo_count};
		depth_wide = (`RIC_CNT_W + 1)'(FIFO_DEPTH);
		// a level above the depth saturates instead of wrapping
		if (water_wide > depth_wide) begin
			fifo_high_status = 1'b1;
		end else begin
			fifo_high_status = count_wide >= (depth_wide - water_wide);
		end
		fifo_low_status = count_wide <= water_wide;
	end

	// hardware event vectors for both flag registers
	logic [`RIC_FLAG_W-1:0] hw_pri;
	logic [`RIC_FLAG_W-1:0] hw_sec;
	logic                   cmd_is_idle;
	logic                   tx_to_eof;

	always_comb begin
		cmd_is_idle = (events_in.command == `RIC_CMD_IDLE);
		tx_to_eof   = (cur.tx_last == RIC_TX_DATA)
			&& (events_in.tx_phase == RIC_TX_EOF);
		hw_pri = '0;
		hw_pri[`RIC_P_TX]   = tx_to_eof;
		hw_pri[`RIC_P_RX]   = events_in.receive_end;
		hw_pri[`RIC_P_IDLE] = cur.cmd_busy && cmd_is_idle;
		hw_pri[`RIC_P_HIGH] = fifo_high_status && !cur.high_seen;
		hw_pri[`RIC_P_LOW]  = fifo_low_status && !cur.low_seen;
		hw_pri[`RIC_P_ERR]  = |events_in.error_bits;
		hw_pri[`RIC_P_SOF]  = events_in.frame_start;
		hw_sec = '0;
		hw_sec[`RIC_S_TIMER0 +: `RIC_TIMERS] = events_in.timer_underflow;
		hw_sec[`RIC_S_CARD] = events_in.card_detect;
	end

	// write strobes per register
	logic wr_fp;
	logic wr_fs;
	logic wr_mp;
	logic wr_ms;
	logic wr_pc;
	logic wr_wl;

	always_comb begin
		wr_fp = wr_in && hit(addr_in, `RIC_OFS_FLAGS_PRI);
		wr_fs = wr_in && hit(addr_in, `RIC_OFS_FLAGS_SEC);
		wr_mp = wr_in && hit(addr_in, `RIC_OFS_MASK_PRI);
		wr_ms = wr_in && hit(addr_in, `RIC_OFS_MASK_SEC);
		wr_pc = wr_in && hit(addr_in, `RIC_OFS_PIN_CTRL);
		wr_wl = wr_in && hit(addr_in, `RIC_OFS_WATER);
	end

	// merged flag values; hardware set wins over a software clear
	logic [`RIC_FLAG_W-1:0] fp_keep;
	logic [`RIC_FLAG_W-1:0] fs_keep;
	logic [`RIC_FLAG_W-1:0] fp_new;
	logic [`RIC_FLAG_W-1:0] fs_new;
	logic [`RIC_FLAG_W-1:0] fs_others;
	logic                   others_pending;
	logic                   any_pending;

	always_comb begin
		fp_keep = cur.flags_pri;
		fs_keep = cur.flags_sec;
		if (wr_fp) begin
			fp_keep = (cur.flags_pri & ~clear_bits(wr_data_in))
				| set_bits(wr_data_in);
		end
		if (wr_fs) begin
			// timer flags are reachable here like any other
			fs_keep = (cur.flags_sec & ~clear_bits(wr_data_in))
				| set_bits(wr_data_in);
		end
		fp_new = fp_keep | hw_pri;
		fs_others = (fs_keep | hw_sec) & ~(`RIC_FLAG_W'(1) << `RIC_S_ANY);
		// global flag looks at every other source through its enable
		others_pending = |(fp_new & cur.mask_pri)
			|| |(fs_others & cur.mask_sec);
		fs_new = fs_keep | hw_sec;
		if (others_pending) begin
			fs_new[`RIC_S_ANY] = 1'b1;
		end
		// only enabled requests reach the indication
		any_pending = |(fp_new & cur.mask_pri)
			|| |(fs_new & cur.mask_sec);
	end

	// read mux; data stand in the cycle after the strobe only
	logic [`RIC_DATA_W-1:0] rd_mux;
	logic [`RIC_DATA_W-1:0] status1;

	always_comb begin
		status1 = '0;
		status1[`RIC_ST_IRQ]  = cur.irq;
		status1[`RIC_ST_HIGH] = fifo_high_status;
		status1[`RIC_ST_LOW]  = fifo_low_status;
		rd_mux = `RIC_RST_DATA;
		// bit 7 of the flag and mask registers reads zero: it is a write qualifier, not storage
		unique case (addr_in)
			`RIC_OFS_FLAGS_PRI: rd_mux = {1'b0, cur.flags_pri};
			`RIC_OFS_FLAGS_SEC: rd_mux = {1'b0, cur.flags_sec};
			`RIC_OFS_MASK_PRI:  rd_mux = {1'b0, cur.mask_pri};
			`RIC_OFS_MASK_SEC:  rd_mux = {1'b0, cur.mask_sec};
			`RIC_OFS_STATUS1:   rd_mux = status1;
			`RIC_OFS_PIN_CTRL:  rd_mux = {6'h00, cur.pin_ctrl};
			`RIC_OFS_WATER:     rd_mux = cur.water;
			default:            rd_mux = `RIC_RST_DATA;
		endcase
	end

	// next state
	always_comb begin
		next_cur = cur;
		next_cur.flags_pri = fp_new;
		next_cur.flags_sec = fs_new;
		if (wr_mp) begin
			next_cur.mask_pri = qualify_write(cur.mask_pri, wr_data_in);
		end
		if (wr_ms) begin
			next_cur.mask_sec = qualify_write(cur.mask_sec, wr_data_in);
		end
		if (wr_pc) begin
			next_cur.pin_ctrl = wr_data_in[1:0];
		end
		if (wr_wl) begin
			next_cur.water = wr_data_in;
		end
		// edge memory: a flag cleared while the level holds stays clear
		next_cur.high_seen = fifo_high_status;
		next_cur.low_seen  = fifo_low_status;
		next_cur.tx_last   = events_in.tx_phase;
		next_cur.cmd_busy  = !cmd_is_idle;
		// indication follows the merged flags by one register stage
		next_cur.irq = any_pending;
		if (cur.pin_ctrl[`RIC_PC_ENABLE]) begin
			next_cur.irq_pin = any_pending ^ cur.pin_ctrl[`RIC_PC_INVERT];
		end else begin
			// pin parked at its inactive level while not activated
			next_cur.irq_pin = cur.pin_ctrl[`RIC_PC_INVERT];
		end
		if (rd_in) begin
			next_cur.rd_data = rd_mux;
		end else begin
			next_cur.rd_data = `RIC_RST_DATA;
		end
	end

	// single state register; the error flag is level-driven by design
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cur.flags_pri <= `RIC_RST_FLAGS;
			cur.flags_sec <= `RIC_RST_FLAGS;
			cur.mask_pri  <= `RIC_RST_MASK;
			cur.mask_sec  <= `RIC_RST_MASK;
			cur.pin_ctrl  <= `RIC_RST_PIN;
			cur.water     <= `RIC_RST_WATER;
			// seen bits start high so a level present at reset is no edge
			cur.high_seen <= 1'b1;
			cur.low_seen  <= 1'b1;
			cur.tx_last   <= RIC_TX_IDLE;
			cur.cmd_busy  <= 1'b0;
			cur.irq       <= 1'b0;
			cur.irq_pin   <= 1'b0;
			cur.rd_data   <= `RIC_RST_DATA;
		end else begin
			cur <= next_cur;
		end
	end

	// outputs straight from the state register
	assign rd_data_out = cur.rd_data;
	assign irq_out     = cur.irq;
	assign irq_pin_out = cur.irq_pin;

endmodule

`default_nettype wire

// file: ric_host.sv
`default_nettype none

module ric_host (
	input  wire logic       clk_in,      // system clock
	input  wire logic [7:0] rd_data_in,  // read data from the block
	output var  logic [7:0] addr_out,    // register address
	output var  logic [7:0] wr_data_out, // write data
	output var  logic       wr_out,      // write strobe
	output var  logic       rd_out       // read strobe
);
	// quiet bus from time zero
	initial begin
		addr_out = 8'h00;
		wr_data_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end

	// one write cycle and a quiet one, so a strobe is never set twice at once
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr_out <= a;
		wr_data_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		wr_data_out <= ~d;
		@(posedge clk_in);
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		@(posedge clk_in);
		d = rd_data_in;
	endtask
endmodule

`default_nettype wire

// file: ric_params.svh
`ifndef RIC_PARAMS_SVH
`define RIC_PARAMS_SVH

// register offsets on the plain register port
`define RIC_OFS_FLAGS_PRI  8'h00
`define RIC_OFS_FLAGS_SEC  8'h01
`define RIC_OFS_MASK_PRI   8'h02
`define RIC_OFS_MASK_SEC   8'h03
`define RIC_OFS_STATUS1    8'h04
`define RIC_OFS_PIN_CTRL   8'h05
`define RIC_OFS_WATER      8'h06

// widths
`define RIC_DATA_W   8
`define RIC_ADDR_W   8
`define RIC_FLAG_W   7
`define RIC_CNT_W    10
`define RIC_ERR_W    8
`define RIC_CMD_W    4
`define RIC_TIMERS   5

// set/clear qualifier position in a flag or mask write
`define RIC_QUAL_BIT 7

// primary flag positions
`define RIC_P_TX     0
`define RIC_P_RX     1
`define RIC_P_IDLE   2
`define RIC_P_HIGH   3
`define RIC_P_LOW    4
`define RIC_P_ERR    5
`define RIC_P_SOF    6

// secondary flag positions (timers occupy 0..4)
`define RIC_S_TIMER0 0
`define RIC_S_CARD   5
`define RIC_S_ANY    6

// status and pin control positions
`define RIC_ST_IRQ      0
`define RIC_ST_HIGH     1
`define RIC_ST_LOW      2
`define RIC_PC_ENABLE   0
`define RIC_PC_INVERT   1

// reset values
`define RIC_RST_FLAGS 7'h00
`define RIC_RST_MASK  7'h00
`define RIC_RST_PIN   2'h0
`define RIC_RST_WATER 8'h08
`define RIC_RST_DATA  8'h00
`define RIC_CMD_IDLE  4'h0

`endif

// file: ric_pkg.sv
`default_nettype none
`include "ric_params.svh"

package ric_pkg;

	// transmitter phase, gray coded along idle -> data -> end of frame
	typedef enum logic [1:0] {
		RIC_TX_IDLE = 2'h0,
		RIC_TX_DATA = 2'h1,
		RIC_TX_EOF  = 2'h3,
		RIC_TX_WAIT = 2'h2
	} ric_tx_phase_type;

	// one-cycle event pulses and levels from the neighbouring units
	typedef struct packed {
		logic [`RIC_TIMERS-1:0] timer_underflow;
		logic                   receive_end;
		logic                   frame_start;
		logic                   card_detect;
		logic [`RIC_ERR_W-1:0]  error_bits;
		logic [`RIC_CMD_W-1:0]  command;
		ric_tx_phase_type       tx_phase;
		logic [`RIC_CNT_W-1:0]  fifo_count;
	} ric_events_type;

	// whole state of the controller
	typedef struct packed {
		logic [`RIC_FLAG_W-1:0] flags_pri;
		logic [`RIC_FLAG_W-1:0] flags_sec;
		logic [`RIC_FLAG_W-1:0] mask_pri;
		logic [`RIC_FLAG_W-1:0] mask_sec;
		logic [1:0]             pin_ctrl;
		logic [`RIC_DATA_W-1:0] water;
		logic                   high_seen;
		logic                   low_seen;
		ric_tx_phase_type       tx_last;
		logic                   cmd_busy;
		logic                   irq;
		logic                   irq_pin;
		logic [`RIC_DATA_W-1:0] rd_data;
	} ric_state_type;

endpackage

`default_nettype wire

// file: ric_properties.sv
`default_nettype none

module ric_properties
	import ric_pkg::*;
(
	input wire logic           clk_in,      // system clock
	input wire logic           rst_in,      // sync reset, high
	input wire logic     [7:0] addr_in,     // register address
	input wire logic     [7:0] wr_data_in,  // write data
	input wire logic           wr_in,       // write strobe
	input wire logic           rd_in,       // read strobe
	input wire ric_events_type events_in,   // unit events
	input wire logic     [7:0] rd_data_out, // read data
	input wire logic           irq_out,     // pending indication
	input wire logic           irq_pin_out  // pin level
);
	logic [1:0] pc;

	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// shadow of the pin control bits, the pin cannot be judged without them
	always_ff @(posedge clk_in) begin
		if (rst_in)
			pc <= 2'h0;
		else if (wr_in && addr_in == 8'h05)
			pc <= wr_data_in[1:0];
	end

	sequence rdq(logic [7:0] a);
		rd_in && addr_in == a;
	endsequence

	AST_RD_IDLE_ZERO: assert property (!$past(rd_in) |-> rd_data_out == 8'h00)
		else $error("read data not zero outside a read");
	AST_QUAL_READS_LOW: assert property (rd_in && addr_in < 8'h04 |=> !rd_data_out[7])
		else $error("qualifier bit read back high");
	AST_SET_ONES: assert property (wr_in && addr_in == 8'h00 && wr_data_in[7] ##2 rdq(8'h00)
		|=> ((rd_data_out | ~$past(wr_data_in, 3)) & 8'h7f) == 8'h7f)
		else $error("qualified set lost a bit");
	AST_STATUS_IRQ: assert property (rdq(8'h04) |=> rd_data_out[0] == $past(irq_out))
		else $error("status bit differs from indication");
	AST_PIN_LEVEL: assert property (pc == $past(pc)
		|-> irq_pin_out == (pc[0] ? irq_out ^ pc[1] : pc[1]))
		else $error("pin level wrong");
	AST_TIMER0: assert property (events_in.timer_underflow[0] ##1 rdq(8'h01) |=> rd_data_out[0])
		else $error("timer flag missing");
	AST_TX_DONE: assert property (events_in.tx_phase == RIC_TX_EOF
		&& $past(events_in.tx_phase) == RIC_TX_DATA ##1 rdq(8'h00) |=> rd_data_out[0])
		else $error("transmit done flag missing");
	AST_RX_DONE: assert property (events_in.receive_end ##1 rdq(8'h00) |=> rd_data_out[1])
		else $error("receive done flag missing");
	AST_IDLE: assert property ($past(events_in.command) != 4'h0
		&& events_in.command == 4'h0 ##1 rdq(8'h00) |=> rd_data_out[2])
		else $error("idle flag missing");

	CVR_IRQ: cover property ($rose(irq_out));
	CVR_PIN_INV: cover property (pc == 2'h3 && irq_pin_out);
	CVR_UNMAPPED: cover property (rd_in && addr_in > 8'h06);
endmodule

`default_nettype wire

// file: testbench.sv
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import ric_pkg::*;

	logic           clk_in = 1'b0;
	logic           rst_in = 1'b1;
	logic     [7:0] addr, wdata, rdata, w;
	logic           wr, rd, irq, pin;
	logic     [6:0] m;
	ric_events_type ev = '0;
	int             miscompares = 0;
	int             n_tests = 0;
	int             b, o;
	// flag place per event kind: bit 3 selects the register, bits 2:0 the bit
	localparam logic [3:0] EXP [13] = '{0, 1, 2, 5, 6, 13, 8, 9, 10, 11, 12, 3, 4};

	always #10 clk_in = ~clk_in;

	ric_host host_u (.clk_in(clk_in), .rd_data_in(rdata), .addr_out(addr),
		.wr_data_out(wdata), .wr_out(wr), .rd_out(rd));
	ric_controller #(.FIFO_DEPTH(512)) dut_u (.clk_in(clk_in), .rst_in(rst_in),
		.addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .events_in(ev),
		.rd_data_out(rdata), .irq_out(irq), .irq_pin_out(pin));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host_u.rd(a, d);
		chk(d, e);
	endtask

	// expected register after a qualified write
	function automatic logic [6:0] qual(input logic [6:0] old, input logic [7:0] wd);
		return wd[7] ? (old | wd[6:0]) : (old & ~wd[6:0]);
	endfunction

	// one event kind for the cycles it needs, then quiet all but the fill count
	task automatic fire(input int k);
		ric_events_type e;
		case (k)
			0: begin
				ev.tx_phase <= RIC_TX_DATA;
				@(posedge clk_in);
				ev.tx_phase <= RIC_TX_EOF;
			end
			1: ev.receive_end <= 1'b1;
			2: begin
				ev.command <= 4'h5;
				@(posedge clk_in);
				ev.command <= 4'h0;
			end
			3: ev.error_bits <= 8'($urandom_range(255, 1));
			4: ev.frame_start <= 1'b1;
			5: ev.card_detect <= 1'b1;
			11: ev.fifo_count <= 10'd512;
			12: ev.fifo_count <= 10'd0;
			default: ev.timer_underflow <= 5'h01 << (k - 6);
		endcase
		@(posedge clk_in);
		e = '0;
		e.fifo_count = ev.fifo_count;
		ev <= e;
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		void'($urandom(32'h9773));
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		// reset values, address 7 is unmapped and reads zero
		for (int i = 0; i < 8; i++)
			rdchk(8'(i), i == 4 ? 8'h04 : (i == 6 ? 8'h08 : 8'h00));
		$display("test reset values done");
		// random set and clear sequences on every flag and mask register
		for (int r = 0; r < 4; r++) begin
			m = 7'h00;
			repeat (6) begin
				w = 8'($urandom);
				host_u.wr(8'(r), w);
				m = qual(m, w);
				rdchk(8'(r), {1'b0, m});
			end
			host_u.wr(8'(r), 8'h7f);
		end
		w = 8'($urandom);
		host_u.wr(8'h06, w);
		rdchk(8'h06, w);
		host_u.wr(8'h06, 8'h08);
		$display("test qualified writes done");
		// every event source in turn, flags cleared before each
		for (int k = 0; k < 13; k++) begin
			host_u.wr(8'h00, 8'h7f);
			host_u.wr(8'h01, 8'h7f);
			fire(k);
			// each source lands on exactly its own flag bit, nothing else set in that register
			rdchk({7'h0, EXP[k][3]}, 8'h01 << EXP[k][2:0]);
		end
		$display("test event sources done");
		// mask gating, status bit, global flag and pin polarity
		b = $urandom_range(6, 0);
		o = (b + 1) % 7;
		host_u.wr(8'h00, 8'h7f);
		host_u.wr(8'h01, 8'h7f);
		host_u.wr(8'h05, 8'h01);
		host_u.wr(8'h02, 8'h80 | (8'h01 << b));
		host_u.wr(8'h00, 8'h80 | (8'h01 << o));
		rdchk(8'h04, 8'h04);
		chk({7'h0, pin}, 8'h00);
		chk({7'h0, irq}, 8'h00);
		host_u.wr(8'h00, 8'h80 | (8'h01 << b));
		rdchk(8'h04, 8'h05);
		chk({7'h0, pin}, 8'h01);
		chk({7'h0, irq}, 8'h01);
		rdchk(8'h01, 8'h40);
		host_u.wr(8'h02, 8'h01 << b);
		host_u.wr(8'h05, 8'h03);
		rdchk(8'h04, 8'h04);
		chk({7'h0, pin}, 8'h01);
		chk({7'h0, irq}, 8'h00);
		$display("test mask and pin done");
		complete_run();
	end

	// ceiling on the whole run in case the sequence stalls
	initial begin
		repeat (20000) @(posedge clk_in);
		miscompares++;
		complete_run();
	end
endmodule

bind ric_controller ric_properties chk_u (.clk_in(clk_in), .rst_in(rst_in),
	.addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
	.events_in(events_in), .rd_data_out(rd_data_out), .irq_out(irq_out),
	.irq_pin_out(irq_pin_out));

`default_nettype wire
